/* verilog/mcb_pkg.sv */
// Package: constants and field layout of the motor algorithm configuration bank
// Notes on behaviour
// - Words decode at 80h..8Eh and 94h..9Eh, two apart, none between.
// - The five words at 80h through 88h come out of reset all zero.
// - Words from 8Ah upward have no defined reset contents.
// - Speed detect word is 32 bits, every field read/write, resets zero.
// - Bit 30 of the speed detect word enables initial speed detection.
// - Bit 29 of the speed detect word enables braking.
// - Bit 28 of the speed detect word enables floating outputs.
// - Bit 27 of the speed detect word enables backward drive.
// - Bit 26 enables catching a spinning motor; bit 31 reserved read/write.
// - Other fields at 25:22, 21, 20, 19:17, 16:13, 12:9, 8:6, 5:2, 1:0.
// - R means readable, W writable, dash value gives reset contents.
package mcb_pkg;
  localparam int unsigned MCB_ADDR_W       = 12;
  localparam int unsigned MCB_DATA_W       = 32;
  localparam int unsigned MCB_NUM_WORDS    = 14;
  localparam int unsigned MCB_NUM_ZERO_RST = 5;
  localparam int unsigned MCB_IDX_W        = 4;
  localparam int unsigned MCB_RD_LAT       = 1;
  typedef logic [MCB_ADDR_W-1:0] mcb_addr_t;
  typedef logic [MCB_DATA_W-1:0] mcb_word_t;
  // Word offsets in the memory address field, index order
  localparam mcb_addr_t MCB_OFFS [MCB_NUM_WORDS] = '{
    12'h080, 12'h082, 12'h084, 12'h086, 12'h088, 12'h08A, 12'h08C,
    12'h08E, 12'h094, 12'h096, 12'h098, 12'h09A, 12'h09C, 12'h09E};
  localparam mcb_addr_t MCB_OFF_ISD = 12'h080;
  localparam mcb_addr_t MCB_OFF_REV = 12'h082;
  localparam mcb_word_t MCB_RST_ZERO  = 32'h0000_0000;
  // Fill for words without defined reset contents
  localparam mcb_word_t MCB_RST_UNDEF = 32'h0000_0000;
  // Speed detect word field positions
  localparam int unsigned MCB_RSVD_BIT  = 31;
  localparam int unsigned MCB_ISD_BIT   = 30;
  localparam int unsigned MCB_BRK_BIT   = 29;
  localparam int unsigned MCB_FLT_BIT   = 28;
  localparam int unsigned MCB_BWD_BIT   = 27;
  localparam int unsigned MCB_CTH_BIT   = 26;
  localparam int unsigned MCB_CTT_LSB   = 22;
  localparam int unsigned MCB_CTT_W     = 4;
  localparam int unsigned MCB_SIDE_BIT  = 21;
  localparam int unsigned MCB_EXIT_BIT  = 20;
  localparam int unsigned MCB_BCUR_LSB  = 17;
  localparam int unsigned MCB_BCUR_W    = 3;
  localparam int unsigned MCB_BDUR_LSB  = 13;
  localparam int unsigned MCB_BDUR_W    = 4;
  localparam int unsigned MCB_FDUR_LSB  = 9;
  localparam int unsigned MCB_FDUR_W    = 4;
  localparam int unsigned MCB_STAT_LSB  = 6;
  localparam int unsigned MCB_STAT_W    = 3;
  localparam int unsigned MCB_HAND_LSB  = 2;
  localparam int unsigned MCB_HAND_W    = 4;
  localparam int unsigned MCB_OLC_LSB   = 0;
  localparam int unsigned MCB_OLC_W     = 2;
endpackage : mcb_pkg

/* verilog/mcb_dec_if.sv */
// Interface: address decode request and result inside the bank
`timescale 1ns/1ps
`default_nettype none
interface mcb_dec_if;
  import mcb_pkg::*;
  mcb_addr_t              addr;
  logic                   hit;
  logic [MCB_IDX_W-1:0]   idx;
  modport dec (input addr, output hit, output idx);
  modport usr (output addr, input hit, input idx);
endinterface : mcb_dec_if
`default_nettype wire

/* verilog/mcb_addr_dec.sv */
// Module: maps a memory address onto a word index of the bank
`timescale 1ns/1ps
`default_nettype none
module mcb_addr_dec
  import mcb_pkg::*;
(
  mcb_dec_if.dec dif
);
  logic [MCB_NUM_WORDS-1:0] match;

  // One comparator per listed word; gaps and odd offsets never match
  for (genvar g = 0; g < MCB_NUM_WORDS; g++) begin : g_cmp
    assign match[g] = (dif.addr == MCB_OFFS[g]);
  end

  // Encode the single match into an index
  always_comb begin
    dif.idx = '0;
    for (int i = 0; i < MCB_NUM_WORDS; i++) begin
      if (match[i]) begin
        dif.idx = MCB_IDX_W'(i);
      end
    end
  end
  assign dif.hit = |match;
endmodule // mcb_addr_dec
`default_nettype wire

/* verilog/mcb_isd_view.sv */
// Module: splits the speed detect word into named control fields
`timescale 1ns/1ps
`default_nettype none
module mcb_isd_view
  import mcb_pkg::*;
(
  input  wire logic [MCB_DATA_W-1:0] word,
  output logic                       speed_detect_enable,
  output logic                       braking_enable,
  output logic                       float_outputs_enable,
  output logic                       backward_drive_enable,
  output logic                       catch_spin_enable,
  output logic [MCB_CTT_W-1:0]       catch_spin_threshold,
  output logic                       braking_side_select,
  output logic                       braking_exit_select,
  output logic [MCB_BCUR_W-1:0]      braking_current_threshold,
  output logic [MCB_BDUR_W-1:0]      braking_duration,
  output logic [MCB_FDUR_W-1:0]      float_duration,
  output logic [MCB_STAT_W-1:0]      stationary_threshold,
  output logic [MCB_HAND_W-1:0]      backward_handoff_threshold,
  output logic [MCB_OLC_W-1:0]       backward_openloop_current
);
  // Enables, high means enabled
  assign speed_detect_enable   = word[MCB_ISD_BIT];
  assign braking_enable        = word[MCB_BRK_BIT];
  assign float_outputs_enable  = word[MCB_FLT_BIT];
  assign backward_drive_enable = word[MCB_BWD_BIT];
  assign catch_spin_enable     = word[MCB_CTH_BIT];
  // Multi-bit settings, raw codes for the algorithm
  assign catch_spin_threshold       = word[MCB_CTT_LSB +: MCB_CTT_W];
  assign braking_side_select        = word[MCB_SIDE_BIT];
  assign braking_exit_select        = word[MCB_EXIT_BIT];
  assign braking_current_threshold  = word[MCB_BCUR_LSB +: MCB_BCUR_W];
  assign braking_duration           = word[MCB_BDUR_LSB +: MCB_BDUR_W];
  assign float_duration             = word[MCB_FDUR_LSB +: MCB_FDUR_W];
  assign stationary_threshold       = word[MCB_STAT_LSB +: MCB_STAT_W];
  assign backward_handoff_threshold = word[MCB_HAND_LSB +: MCB_HAND_W];
  assign backward_openloop_current  = word[MCB_OLC_LSB +: MCB_OLC_W];
endmodule // mcb_isd_view
`default_nettype wire

/* verilog/mcb_cfg_bank.sv */
// Module: motor algorithm configuration register bank, word access port
`timescale 1ns/1ps
`default_nettype none
module mcb_cfg_bank
  import mcb_pkg::*;
(
  input  wire logic                                clk,
  input  wire logic                                rst_b,
  input  wire logic [MCB_ADDR_W-1:0]               acc_addr,
  input  wire logic                                acc_wr,
  input  wire logic                                acc_rd,
  input  wire logic [MCB_DATA_W-1:0]               acc_wdata,
  output logic      [MCB_DATA_W-1:0]               acc_rdata,
  output logic                                     acc_rvalid,
  output logic                                     acc_miss,
  output logic      [MCB_NUM_WORDS*MCB_DATA_W-1:0] cfg_words,
  output logic                                     speed_detect_enable,
  output logic                                     braking_enable,
  output logic                                     float_outputs_enable,
  output logic                                     backward_drive_enable,
  output logic                                     catch_spin_enable,
  output logic      [MCB_CTT_W-1:0]                catch_spin_threshold,
  output logic                                     braking_side_select,
  output logic                                     braking_exit_select,
  output logic      [MCB_BCUR_W-1:0]               braking_current_threshold,
  output logic      [MCB_BDUR_W-1:0]               braking_duration,
  output logic      [MCB_FDUR_W-1:0]               float_duration,
  output logic      [MCB_STAT_W-1:0]               stationary_threshold,
  output logic      [MCB_HAND_W-1:0]               backward_handoff_threshold,
  output logic      [MCB_OLC_W-1:0]                backward_openloop_current
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------

  typedef struct packed {
    mcb_word_t [MCB_NUM_WORDS-1:0] words;
    mcb_word_t                     rdata;
    logic                          rvalid;
    logic                          miss;
    logic                          settled;
  } mcb_state_s;

  // Low five words zero, upper words only a fill value
  localparam mcb_state_s MCB_ST_RST = '{
    words: {{(MCB_NUM_WORDS-MCB_NUM_ZERO_RST){MCB_RST_UNDEF}},
            {MCB_NUM_ZERO_RST{MCB_RST_ZERO}}},
    rdata:   MCB_RST_ZERO,
    rvalid:  1'b0,
    miss:    1'b0,
    settled: 1'b0
  };

  mcb_state_s st_r;
  mcb_state_s st_nxt;

  mcb_dec_if dif ();

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------

  // Whole twelve-bit address field is compared, section and page are not
  assign dif.addr = acc_addr;

  mcb_addr_dec u_dec (
    .dif (dif)
  );

  // ----------------------------------------------------------------
  // Access logic
  // ----------------------------------------------------------------

  // Read samples the word before a write in the same cycle lands,
  // so a combined access returns old contents and stores the new
  always_comb begin
    st_nxt         = st_r;
    st_nxt.settled = 1'b1;
    st_nxt.rvalid  = acc_rd;
    st_nxt.miss    = (acc_rd | acc_wr) & ~dif.hit;
    if (acc_rd) begin
      if (dif.hit) begin
        st_nxt.rdata = st_r.words[dif.idx];
      end else begin
        st_nxt.rdata = MCB_RST_ZERO;
      end
    end
    // Unmapped writes are dropped, so reserved space never changes
    if (acc_wr && dif.hit) begin
      st_nxt.words[dif.idx] = acc_wdata;
    end
  end

  // Single state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_r <= MCB_ST_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------

  // All data outputs straight from flops
  assign acc_rdata  = st_r.rdata;
  assign acc_rvalid = st_r.rvalid;
  assign acc_miss   = st_r.miss;
  assign cfg_words  = st_r.words;

  // Speed detect word broken into fields for the algorithm
  mcb_isd_view u_view (
    .word                       (st_r.words[0]),
    .speed_detect_enable        (speed_detect_enable),
    .braking_enable             (braking_enable),
    .float_outputs_enable       (float_outputs_enable),
    .backward_drive_enable      (backward_drive_enable),
    .catch_spin_enable          (catch_spin_enable),
    .catch_spin_threshold       (catch_spin_threshold),
    .braking_side_select        (braking_side_select),
    .braking_exit_select        (braking_exit_select),
    .braking_current_threshold  (braking_current_threshold),
    .braking_duration           (braking_duration),
    .float_duration             (float_duration),
    .stationary_threshold       (stationary_threshold),
    .backward_handoff_threshold (backward_handoff_threshold),
    .backward_openloop_current  (backward_openloop_current)
  );

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  // Zero-reset words seen right after release
  chk_reset_zero_words: assert property (
    @(posedge clk) disable iff (!rst_b)
    !st_r.settled |-> (cfg_words[5*MCB_DATA_W-1:0] == '0)
  ) else $error("low words not zero after reset");

  // Every enable and field clear out of reset
  chk_isd_reset_fields: assert property (
    @(posedge clk) disable iff (!rst_b)
    !st_r.settled |-> !speed_detect_enable && !braking_enable
      && !float_outputs_enable && !backward_drive_enable
      && !catch_spin_enable && (catch_spin_threshold == '0)
      && (braking_duration == '0) && (backward_openloop_current == '0)
      && !braking_side_select && !braking_exit_select
      && (braking_current_threshold == '0) && (float_duration == '0)
      && (stationary_threshold == '0) && (backward_handoff_threshold == '0)
  ) else $error("speed detect fields not clear after reset");

  // Read answers exactly one cycle later
  chk_read_answer_time: assert property (
    @(posedge clk) disable iff (!rst_b)
    acc_rd |=> acc_rvalid ##1 (!acc_rvalid || $past(acc_rd))
  ) else $error("read answer not one cycle after request");

  // Write then read returns written data
  chk_write_read_back: assert property (
    @(posedge clk) disable iff (!rst_b)
    (acc_wr && dif.hit) ##1 (acc_rd && !acc_wr
      && acc_addr == $past(acc_addr))
    |=> acc_rvalid && !acc_miss && (acc_rdata == $past(acc_wdata, 2))
  ) else $error("read back differs from last write");

  // Gap between 8Eh and 94h and odd offsets are unmapped
  chk_gap_unmapped: assert property (
    @(posedge clk) disable iff (!rst_b)
    (acc_rd && (acc_addr == 12'h090 || acc_addr == 12'h092
      || acc_addr[0]))
    |=> acc_miss && (acc_rdata == MCB_RST_ZERO)
  ) else $error("gap or odd offset decoded as a word");

  // Listed offsets always hit
  chk_listed_hit: assert property (
    @(posedge clk) disable iff (!rst_b)
    (acc_rd && acc_addr >= 12'h080 && acc_addr <= 12'h09E
      && !acc_addr[0] && acc_addr != 12'h090 && acc_addr != 12'h092)
    |=> !acc_miss
  ) else $error("listed offset reported as unmapped");

  // Unmapped write leaves the whole bank alone
  chk_unmapped_write: assert property (
    @(posedge clk) disable iff (!rst_b)
    (acc_wr && !dif.hit) |=> $stable(cfg_words) && acc_miss
  ) else $error("unmapped write changed the bank");

  // Write to another word leaves speed detect word untouched
  chk_no_side_effect: assert property (
    @(posedge clk) disable iff (!rst_b)
    (acc_wr && acc_addr == MCB_OFF_REV)
    |=> $stable(st_r.words[0])
      && (cfg_words[2*MCB_DATA_W-1:MCB_DATA_W] == $past(acc_wdata))
  ) else $error("write disturbed a neighbouring word");

  // Detection enable follows bit 30
  chk_detect_enable: assert property (
    @(posedge clk) disable iff (!rst_b)
    (acc_wr && acc_addr == MCB_OFF_ISD)
    |=> speed_detect_enable == $past(acc_wdata[MCB_ISD_BIT])
  ) else $error("detect enable does not follow bit 30");

  // Braking enable follows bit 29
  chk_brake_enable: assert property (
    @(posedge clk) disable iff (!rst_b)
    (acc_wr && acc_addr == MCB_OFF_ISD)
    |=> braking_enable == $past(acc_wdata[MCB_BRK_BIT])
  ) else $error("braking enable does not follow bit 29");

  // Float enable follows bit 28
  chk_float_enable: assert property (
    @(posedge clk) disable iff (!rst_b)
    (acc_wr && acc_addr == MCB_OFF_ISD)
    |=> float_outputs_enable == $past(acc_wdata[MCB_FLT_BIT])
  ) else $error("float enable does not follow bit 28");

  // Backward drive enable follows bit 27
  chk_backward_enable: assert property (
    @(posedge clk) disable iff (!rst_b)
    (acc_wr && acc_addr == MCB_OFF_ISD)
    |=> backward_drive_enable == $past(acc_wdata[MCB_BWD_BIT])
  ) else $error("backward enable does not follow bit 27");

  // Catch-spin enable and reserved bit kept as written
  chk_catch_reserved: assert property (
    @(posedge clk) disable iff (!rst_b)
    (acc_wr && acc_addr == MCB_OFF_ISD)
    |=> catch_spin_enable == $past(acc_wdata[MCB_CTH_BIT])
      && st_r.words[0][MCB_RSVD_BIT] == $past(acc_wdata[MCB_RSVD_BIT])
  ) else $error("bit 26 or reserved bit 31 not kept");

  // Multi-bit fields land on their documented bits
  chk_field_layout: assert property (
    @(posedge clk) disable iff (!rst_b)
    (acc_wr && acc_addr == MCB_OFF_ISD)
    |=> catch_spin_threshold == $past(acc_wdata[25:22])
      && braking_side_select == $past(acc_wdata[21])
      && braking_exit_select == $past(acc_wdata[20])
      && braking_current_threshold == $past(acc_wdata[19:17])
      && braking_duration == $past(acc_wdata[16:13])
      && float_duration == $past(acc_wdata[12:9])
      && stationary_threshold == $past(acc_wdata[8:6])
      && backward_handoff_threshold == $past(acc_wdata[5:2])
      && backward_openloop_current == $past(acc_wdata[1:0])
  ) else $error("speed detect field misplaced");

  // Answer flag only ever follows a read
  chk_rvalid_only_read: assert property (
    @(posedge clk) disable iff (!rst_b)
    !acc_rd |=> !acc_rvalid
  ) else $error("answer flag without a read");

  // Miss flag only ever follows an access
  chk_miss_only_access: assert property (
    @(posedge clk) disable iff (!rst_b)
    (!acc_rd && !acc_wr) |=> !acc_miss
  ) else $error("miss flag without an access");

  // Read data holds so a slow host may pick it up late
  chk_rdata_hold: assert property (
    @(posedge clk) disable iff (!rst_b)
    !acc_rd |=> $stable(acc_rdata)
  ) else $error("read data changed without a read");

  // Bank contents move only on a write
  chk_bank_hold: assert property (
    @(posedge clk) disable iff (!rst_b)
    !acc_wr |=> $stable(cfg_words)
  ) else $error("bank changed without a write");

  // Combined access answers old contents and stores the new
  chk_rw_old_data: assert property (
    @(posedge clk) disable iff (!rst_b)
    (acc_rd && acc_wr && acc_addr == 12'h086)
    |=> (acc_rdata == $past(cfg_words[3*MCB_DATA_W +: MCB_DATA_W]))
      && (cfg_words[3*MCB_DATA_W +: MCB_DATA_W] == $past(acc_wdata))
  ) else $error("combined access returned new contents");

  // Reserved bit also clear out of reset
  chk_reserved_reset: assert property (
    @(posedge clk) disable iff (!rst_b)
    !st_r.settled |-> !st_r.words[0][MCB_RSVD_BIT]
  ) else $error("reserved bit set after reset");

  // Whole speed detect word stored, no bit masked
  chk_isd_word_lands: assert property (
    @(posedge clk) disable iff (!rst_b)
    (acc_wr && acc_addr == MCB_OFF_ISD)
    |=> !acc_miss && (cfg_words[MCB_DATA_W-1:0] == $past(acc_wdata))
  ) else $error("speed detect word not stored as written");

  // Read of the speed detect word returns its contents
  chk_isd_read_data: assert property (
    @(posedge clk) disable iff (!rst_b)
    (acc_rd && acc_addr == MCB_OFF_ISD)
    |=> acc_rvalid && (acc_rdata == $past(cfg_words[MCB_DATA_W-1:0]))
  ) else $error("speed detect read data wrong");

  // Writes into the hole between 8Eh and 94h are dropped
  chk_gap_write_ignored: assert property (
    @(posedge clk) disable iff (!rst_b)
    (acc_wr && (acc_addr == 12'h090 || acc_addr == 12'h092))
    |=> acc_miss && $stable(cfg_words)
  ) else $error("write into gap changed the bank");

  // Top offset lands in the last slot
  chk_last_word_slot: assert property (
    @(posedge clk) disable iff (!rst_b)
    (acc_wr && acc_addr == 12'h09E)
    |=> cfg_words[(MCB_NUM_WORDS-1)*MCB_DATA_W +: MCB_DATA_W] == $past(acc_wdata)
  ) else $error("offset 9Eh not stored in last slot");

  // First offset past the hole lands in slot eight
  chk_upper_first_slot: assert property (
    @(posedge clk) disable iff (!rst_b)
    (acc_wr && acc_addr == 12'h094)
    |=> cfg_words[8*MCB_DATA_W +: MCB_DATA_W] == $past(acc_wdata)
  ) else $error("offset 94h not stored in slot eight");

  // Access outputs quiet at the first edge after release
  chk_access_reset: assert property (
    @(posedge clk) disable iff (!rst_b)
    !st_r.settled |-> !acc_rvalid && !acc_miss && (acc_rdata == '0)
  ) else $error("access outputs not quiet after reset");

  // Odd offsets never take a write
  chk_odd_write_ignored: assert property (
    @(posedge clk) disable iff (!rst_b)
    (acc_wr && acc_addr[0]) |=> acc_miss && $stable(cfg_words)
  ) else $error("odd offset write changed the bank");

  // Offsets below the bank never take a write
  chk_low_write_ignored: assert property (
    @(posedge clk) disable iff (!rst_b)
    (acc_wr && acc_addr < 12'h080) |=> acc_miss && $stable(cfg_words)
  ) else $error("low offset write changed the bank");

  // Offsets above the bank never take a write
  chk_high_write_ignored: assert property (
    @(posedge clk) disable iff (!rst_b)
    (acc_wr && acc_addr > 12'h09E) |=> acc_miss && $stable(cfg_words)
  ) else $error("high offset write changed the bank");

endmodule // mcb_cfg_bank
`default_nettype wire

/* test/mcb_host_model.sv */
// Model of the outside controller issuing decoded link requests to the bank
`timescale 1ns/1ps
`default_nettype none
module mcb_host_model
  import mcb_pkg::*;
(
  input  wire logic                  clk,
  output logic      [MCB_ADDR_W-1:0] acc_addr,
  output logic                       acc_wr,
  output logic                       acc_rd,
  output logic      [MCB_DATA_W-1:0] acc_wdata
);
  // ------------------------------------------------------------
  // Request drive
  // ------------------------------------------------------------
  // Quiet bus before the first request
  initial begin
    acc_addr  = 12'h000;
    acc_wr    = 1'b0;
    acc_rd    = 1'b0;
    acc_wdata = 32'h0000_0000;
  end

  // True only at offsets that hold a configuration word
  function automatic logic mapped(input logic [11:0] a);
    return !a[0] && ((a >= 12'h080 && a <= 12'h08E) || (a >= 12'h094 && a <= 12'h09E));
  endfunction

  // One access per call from a falling edge; lines stay up so calls chain back to back
  task automatic xfer(input logic rd, input logic wr, input logic [11:0] a,
                      input logic [31:0] d, input logic probe);
    acc_addr  = a;
    acc_rd    = rd;
    acc_wr    = wr & (probe | mapped(a));
    acc_wdata = d;
    @(negedge clk);
  endtask

  // Release; data shows no stale value once released
  task automatic idle();
    acc_rd    = 1'b0;
    acc_wr    = 1'b0;
    acc_wdata = ~acc_wdata;
  endtask
endmodule // mcb_host_model
`default_nettype wire

/* test/mcb_cfg_bank_tb.sv */
// Self-checking testbench for the configuration register bank
`timescale 1ns/1ps
`default_nettype none
module mcb_cfg_bank_tb;
  import mcb_pkg::*;
  logic                  clk;
  logic                  rst_b;
  logic [MCB_ADDR_W-1:0] acc_addr;
  logic                  acc_wr;
  logic                  acc_rd;
  logic [MCB_DATA_W-1:0] acc_wdata;
  logic [MCB_DATA_W-1:0] acc_rdata;
  logic                  acc_rvalid;
  logic                  acc_miss;
  logic [MCB_NUM_WORDS*MCB_DATA_W-1:0] cfg_words;
  logic sde, bre, foe, bde, cse, bss, bes;
  logic [MCB_CTT_W-1:0]  cst;
  logic [MCB_BCUR_W-1:0] bct;
  logic [MCB_BDUR_W-1:0] bdu;
  logic [MCB_FDUR_W-1:0] fdu;
  logic [MCB_STAT_W-1:0] stt;
  logic [MCB_HAND_W-1:0] bht;
  logic [MCB_OLC_W-1:0]  boc;
  int                    miscompares;
  int                    samples_checked;
  logic [11:0]           bad [8] = '{12'h090, 12'h092, 12'h081, 12'h07E,
                                     12'h0A0, 12'h180, 12'h08F, 12'h000};

  mcb_cfg_bank u_mcb_cfg_bank (
    .clk(clk), .rst_b(rst_b), .acc_addr(acc_addr), .acc_wr(acc_wr), .acc_rd(acc_rd),
    .acc_wdata(acc_wdata), .acc_rdata(acc_rdata), .acc_rvalid(acc_rvalid),
    .acc_miss(acc_miss), .cfg_words(cfg_words), .speed_detect_enable(sde),
    .braking_enable(bre), .float_outputs_enable(foe), .backward_drive_enable(bde),
    .catch_spin_enable(cse), .catch_spin_threshold(cst), .braking_side_select(bss),
    .braking_exit_select(bes), .braking_current_threshold(bct), .braking_duration(bdu),
    .float_duration(fdu), .stationary_threshold(stt), .backward_handoff_threshold(bht),
    .backward_openloop_current(boc));

  mcb_host_model u_mcb_host_model (
    .clk(clk), .acc_addr(acc_addr), .acc_wr(acc_wr), .acc_rd(acc_rd),
    .acc_wdata(acc_wdata));

  // ------------------------------------------------------------
  // Clock, compare and closing
  // ------------------------------------------------------------
  // 125 MHz clock
  always #4 clk = ~clk;

  // Compare one value against its expectation
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic end_sim();
    if (miscompares == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // Offset of word i, worked out independently of the design's table
  function automatic logic [11:0] off(input int i);
    return (i < 8) ? 12'h080 + 12'(2 * i) : 12'h094 + 12'(2 * (i - 8));
  endfunction

  // Distinct data for word i
  function automatic logic [31:0] pat(input int i);
    return 32'h1357_9BDF ^ (32'h0F0F_0000 + 32'(i) * 32'h0111_1111);
  endfunction

  // Read one offset and check the answer
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic miss);
    u_mcb_host_model.xfer(1'b1, 1'b0, a, 32'h0000_0000, 1'b0);
    chk("rvalid", 32'(acc_rvalid), 32'h1);
    chk("miss", 32'(acc_miss), 32'(miss));
    chk("rdata", acc_rdata, exp);
  endtask

  // Decoded fields of the speed detect word
  task automatic fields(input logic [31:0] w);
    chk("speed_detect_enable", 32'(sde), 32'(w[30]));
    chk("braking_enable", 32'(bre), 32'(w[29]));
    chk("float_outputs_enable", 32'(foe), 32'(w[28]));
    chk("backward_drive_enable", 32'(bde), 32'(w[27]));
    chk("catch_spin_enable", 32'(cse), 32'(w[26]));
    chk("catch_spin_threshold", 32'(cst), 32'(w[25:22]));
    chk("braking_side_select", 32'(bss), 32'(w[21]));
    chk("braking_exit_select", 32'(bes), 32'(w[20]));
    chk("braking_current_threshold", 32'(bct), 32'(w[19:17]));
    chk("braking_duration", 32'(bdu), 32'(w[16:13]));
    chk("float_duration", 32'(fdu), 32'(w[12:9]));
    chk("stationary_threshold", 32'(stt), 32'(w[8:6]));
    chk("backward_handoff_threshold", 32'(bht), 32'(w[5:2]));
    chk("backward_openloop_current", 32'(boc), 32'(w[1:0]));
  endtask

  // Five-cycle reset, released at a falling edge
  task automatic do_reset();
    rst_b = 1'b0;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Main sequence
  initial begin
    clk             = 1'b0;
    rst_b           = 1'b0;
    miscompares     = 0;
    samples_checked = 0;
    do_reset();
    chk("reset rvalid", 32'(acc_rvalid), 32'h0);
    chk("reset miss", 32'(acc_miss), 32'h0);
    for (int i = 0; i < 5; i++) chk("reset word", cfg_words[32*i +: 32], 32'h0);
    fields(32'h0);
    for (int i = 0; i < 5; i++) rdchk(off(i), 32'h0, 1'b0);
    // Walking one through every bit of the speed detect word, reserved bit too
    for (int b = 0; b < 32; b++) begin
      u_mcb_host_model.xfer(1'b0, 1'b1, 12'h080, 32'h1 << b, 1'b0);
      chk("write rvalid", 32'(acc_rvalid), 32'h0);
      chk("write miss", 32'(acc_miss), 32'h0);
      chk("write rdata held", acc_rdata, (b == 0) ? 32'h0 : 32'h1 << (b - 1));
      fields(32'h1 << b);
      rdchk(12'h080, 32'h1 << b, 1'b0);
    end
    // Fill every word back to back, then read all back
    for (int i = 0; i < 14; i++) u_mcb_host_model.xfer(1'b0, 1'b1, off(i), pat(i), 1'b0);
    for (int i = 0; i < 14; i++) chk("word", cfg_words[32*i +: 32], pat(i));
    for (int i = 0; i < 14; i++) rdchk(off(i), pat(i), 1'b0);
    // Reserved and gap offsets: write refused, read returns zero
    for (int k = 0; k < 8; k++) begin
      u_mcb_host_model.xfer(1'b0, 1'b1, bad[k], 32'hFFFF_FFFF, 1'b1);
      chk("bad write miss", 32'(acc_miss), 32'h1);
      rdchk(bad[k], 32'h0, 1'b1);
    end
    for (int i = 0; i < 14; i++) chk("word kept", cfg_words[32*i +: 32], pat(i));
    // Read and write together: old contents come back, new ones are stored
    u_mcb_host_model.xfer(1'b1, 1'b1, 12'h086, 32'hDEAD_BEEF, 1'b0);
    chk("rw rdata", acc_rdata, pat(3));
    chk("rw word", cfg_words[96 +: 32], 32'hDEAD_BEEF);
    chk("rw neighbour", cfg_words[128 +: 32], pat(4));
    u_mcb_host_model.idle();
    // Second reset in mid run clears the low five words again
    do_reset();
    for (int i = 0; i < 5; i++) chk("rereset word", cfg_words[32*i +: 32], 32'h0);
    fields(32'h0);
    end_sim();
  end

  // Watchdog: a hang counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    end_sim();
  end
endmodule // mcb_cfg_bank_tb
`default_nettype wire
